// ---- pkg/fac_pkg.sv ----
`default_nettype none
package fac_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [11:0] FAC_OFS_FLT_STAT = 12'hD28;
   localparam logic [11:0] FAC_OFS_HF_STAT  = 12'hD2C;
   localparam logic [11:0] FAC_OFS_MM_ADDR  = 12'hD34;
   localparam logic [11:0] FAC_OFS_BF_ADDR  = 12'hD38;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int          FAC_HF_VECT_BIT  = 1;
   localparam int          FAC_MM_VALID_BIT = 7;
   localparam int          FAC_BF_VALID_BIT = 15;
   localparam logic        FAC_VECT_RST     = 1'b0;
   localparam logic        FAC_VALID_RST    = 1'b0;
   localparam logic [31:0] FAC_RDATA_RST    = 32'h00000000;

   // ****************************************
   // Register select
   // ****************************************
   typedef enum logic [2:0] {
      FAC_REG_NONE,
      FAC_REG_FLT_STAT,
      FAC_REG_HF_STAT,
      FAC_REG_MM_ADDR,
      FAC_REG_BF_ADDR
   } fac_reg_t;

   function automatic fac_reg_t fac_decode(input logic [11:0] ofs);
      fac_reg_t r;
      r = FAC_REG_NONE;
      case (ofs)
         FAC_OFS_FLT_STAT: r = FAC_REG_FLT_STAT;
         FAC_OFS_HF_STAT:  r = FAC_REG_HF_STAT;
         FAC_OFS_MM_ADDR:  r = FAC_REG_MM_ADDR;
         FAC_OFS_BF_ADDR:  r = FAC_REG_BF_ADDR;
         default:          r = FAC_REG_NONE;
      endcase
      return r;
   endfunction : fac_decode
endpackage : fac_pkg
`default_nettype wire

// ---- src/fac_capture.sv ----
`default_nettype none
// ****************************************
// Fault address capture with valid flag
// ****************************************
module fac_capture #(
   parameter bit USE_REQ = 1'b0
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        fault_evt,
   input  wire logic        addr_ok,
   input  wire logic [31:0] req_addr,
   input  wire logic [31:0] sub_addr,
   input  wire logic        sw_wr_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_clr_valid,
   output logic      [31:0] addr_q,
   output logic             valid_q
);
   logic        cap;
   logic [31:0] src_addr;

   assign cap      = fault_evt & addr_ok;
   // Bus class keeps requested address, mem class the sub-access
   assign src_addr = USE_REQ ? req_addr : sub_addr;

   // Address holds until a fault with addr_ok or a write; no reset
   always_ff @(posedge pclk) begin
      if (cap) begin
         addr_q <= src_addr;
      end else if (sw_wr_addr) begin
         addr_q <= sw_wdata;
      end
   end

   // Set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_q <= fac_pkg::FAC_VALID_RST;
      end else begin
         valid_q <= (valid_q & ~sw_clr_valid) | cap;
      end
   end
endmodule : fac_capture
`default_nettype wire

// ---- src/fac_apb_decode.sv ----
`default_nettype none
// ****************************************
// APB address and privilege check
// ****************************************
module fac_apb_decode (
   input  wire logic [11:0]     paddr,
   input  wire logic [2:0]      pprot,
   output fac_pkg::fac_reg_t    reg_sel,
   output logic                 acc_err
);
   always_comb begin
      reg_sel = fac_pkg::fac_decode(paddr);
      // Unmapped or unprivileged access is refused
      acc_err = (reg_sel == fac_pkg::FAC_REG_NONE) | ~pprot[0];
   end
endmodule : fac_apb_decode
`default_nettype wire

// ---- src/fac_top.sv ----
`default_nettype none
// Summary of operation
// - A bus fault on a vector table read sets the vector fault flag, bit 1.
// - The vector fault flag clears only on a write of one to its bit.
// - A memory management fault with mm_addr_ok set loads its address register at 0xD34.
// - An unaligned memory management fault records the sub-access address.
// - A split access may record any byte within the requested span.
// - The memory fault address counts only while its valid flag is set.
// - A bus fault with bus_addr_ok set, other than on a vector table read, loads the bus fault address register at 0xD38.
// - An unaligned bus fault records the address the instruction asked for.
// - The bus fault address counts only while its valid flag is set.
// - Only privileged accesses may read or write the address registers.
module fac_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [2:0]  pprot,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        vect_read_fault,
   input  wire logic        mm_fault,
   input  wire logic        mm_addr_ok,
   input  wire logic [31:0] mm_req_addr,
   input  wire logic [31:0] mm_sub_addr,
   input  wire logic        bus_fault,
   input  wire logic        bus_addr_ok,
   input  wire logic [31:0] bus_req_addr,
   input  wire logic [31:0] bus_sub_addr,
   output logic             hardfault_req,
   output logic             busfault_req
);
   // ****************************************
   // Declarations
   // ****************************************
   fac_pkg::fac_reg_t reg_sel;
   logic              acc_err;
   logic              start;
   logic              done;
   logic              wr_ok;
   logic              pready_q;
   logic              pslverr_q;
   logic       [31:0] prdata_q;
   logic       [31:0] rd_d;
   logic              vect_q;
   logic              hf_req_q;
   logic              bf_req_q;
   logic              wr_hf;
   logic              wr_fs;
   logic              wr_mma;
   logic              wr_bfa;
   logic       [31:0] mm_addr_q;
   logic       [31:0] bf_addr_q;
   logic              mm_valid_q;
   logic              bf_valid_q;

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign hardfault_req = hf_req_q;
   assign busfault_req  = bf_req_q;

   // ****************************************
   // APB slave
   // ****************************************
   fac_apb_decode u_dec (
      .paddr   (paddr),
      .pprot   (pprot),
      .reg_sel (reg_sel),
      .acc_err (acc_err)
   );

   assign start = psel & penable & ~pready_q;
   assign done  = psel & penable & pready_q;
   assign wr_ok = done & pwrite & ~pslverr_q;
   assign wr_hf  = wr_ok & (reg_sel == fac_pkg::FAC_REG_HF_STAT);
   assign wr_fs  = wr_ok & (reg_sel == fac_pkg::FAC_REG_FLT_STAT);
   assign wr_mma = wr_ok & (reg_sel == fac_pkg::FAC_REG_MM_ADDR);
   assign wr_bfa = wr_ok & (reg_sel == fac_pkg::FAC_REG_BF_ADDR);

   // Read mux
   always_comb begin
      rd_d = fac_pkg::FAC_RDATA_RST;
      case (reg_sel)
         fac_pkg::FAC_REG_FLT_STAT: begin
            rd_d[fac_pkg::FAC_MM_VALID_BIT] = mm_valid_q;
            rd_d[fac_pkg::FAC_BF_VALID_BIT] = bf_valid_q;
         end
         fac_pkg::FAC_REG_HF_STAT: begin
            rd_d[fac_pkg::FAC_HF_VECT_BIT] = vect_q;
         end
         fac_pkg::FAC_REG_MM_ADDR: rd_d = mm_addr_q;
         fac_pkg::FAC_REG_BF_ADDR: rd_d = bf_addr_q;
         default:                  rd_d = fac_pkg::FAC_RDATA_RST;
      endcase
   end

   // One wait state, answer registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= fac_pkg::FAC_RDATA_RST;
      end else if (start) begin
         pready_q  <= 1'b1;
         pslverr_q <= acc_err;
         prdata_q  <= (acc_err | pwrite) ? fac_pkg::FAC_RDATA_RST : rd_d;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= fac_pkg::FAC_RDATA_RST;
      end
   end

   // ****************************************
   // Hard fault status
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vect_q <= fac_pkg::FAC_VECT_RST;
      end else begin
         vect_q <= (vect_q & ~(wr_hf & pwdata[fac_pkg::FAC_HF_VECT_BIT]))
                   | vect_read_fault;
      end
   end

   // Vector read faults go to hard fault only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hf_req_q <= 1'b0;
         bf_req_q <= 1'b0;
      end else begin
         hf_req_q <= vect_read_fault;
         bf_req_q <= bus_fault & ~vect_read_fault;
      end
   end

   // ****************************************
   // Address capture
   // ****************************************
   fac_capture #(.USE_REQ(1'b0)) u_mm (
      .pclk         (pclk),
      .presetn      (presetn),
      .fault_evt    (mm_fault),
      .addr_ok      (mm_addr_ok),
      .req_addr     (mm_req_addr),
      .sub_addr     (mm_sub_addr),
      .sw_wr_addr   (wr_mma),
      .sw_wdata     (pwdata),
      .sw_clr_valid (wr_fs & pwdata[fac_pkg::FAC_MM_VALID_BIT]),
      .addr_q       (mm_addr_q),
      .valid_q      (mm_valid_q)
   );

   fac_capture #(.USE_REQ(1'b1)) u_bf (
      .pclk         (pclk),
      .presetn      (presetn),
      .fault_evt    (bus_fault & ~vect_read_fault),
      .addr_ok      (bus_addr_ok),
      .req_addr     (bus_req_addr),
      .sub_addr     (bus_sub_addr),
      .sw_wr_addr   (wr_bfa),
      .sw_wdata     (pwdata),
      .sw_clr_valid (wr_fs & pwdata[fac_pkg::FAC_BF_VALID_BIT]),
      .addr_q       (bf_addr_q),
      .valid_q      (bf_valid_q)
   );

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && penable && !pready_q;
   endsequence

   sequence s_unpriv_answer;
      pready_q && pslverr_q && prdata_q == fac_pkg::FAC_RDATA_RST;
   endsequence

   sequence s_read_ok;
      psel && penable && !pready_q && !acc_err && !pwrite;
   endsequence

   a_vect_set: assert property (
      vect_read_fault |=> vect_q)
      else $error("vector fault flag not set");

   a_vect_w1c: assert property (
      vect_q && !(wr_hf && pwdata[fac_pkg::FAC_HF_VECT_BIT]) |=> vect_q)
      else $error("vector fault flag lost without a one written");

   a_hf_route: assert property (
      vect_read_fault |=> hf_req_q && !bf_req_q)
      else $error("vector fault routed wrongly");

   a_mm_capture: assert property (
      mm_fault && mm_addr_ok |=> mm_valid_q ##0
      mm_addr_q == $past(mm_sub_addr))
      else $error("memory fault address not captured");

   a_mm_subaddr: assert property (
      mm_fault && mm_addr_ok && mm_sub_addr != mm_req_addr
      |=> mm_addr_q != $past(mm_req_addr))
      else $error("memory fault kept requested address");

   a_bf_capture: assert property (
      bus_fault && bus_addr_ok && !vect_read_fault
      |=> bf_valid_q && bf_addr_q == $past(bus_req_addr))
      else $error("bus fault address not captured");

   a_bf_reqaddr: assert property (
      bus_fault && bus_addr_ok && !vect_read_fault
      && bus_sub_addr != bus_req_addr |=> bf_addr_q != $past(bus_sub_addr))
      else $error("bus fault kept sub-access address");

   a_unpriv_refuse: assert property (
      s_setup ##0 !pprot[0] |=> s_unpriv_answer ##1 !pready_q)
      else $error("unprivileged access not refused");

   a_addr_hold: assert property (
      !(mm_fault && mm_addr_ok) && !wr_mma
      |=> mm_addr_q === $past(mm_addr_q))
      else $error("memory fault address changed unprompted");

   a_valid_hold: assert property (
      bf_valid_q && !(wr_fs && pwdata[fac_pkg::FAC_BF_VALID_BIT])
      |=> bf_valid_q)
      else $error("bus fault valid flag lost");

   // ****************************************
   // Route, flag, register and wait state checks
   // ****************************************
   a_vect_clear: assert property (
      wr_hf && pwdata[fac_pkg::FAC_HF_VECT_BIT] && !vect_read_fault
      |=> !vect_q)
      else $error("vector fault flag not cleared by a one");

   a_bf_route: assert property (
      bus_fault && !vect_read_fault |=> bf_req_q && !hf_req_q)
      else $error("plain bus fault routed wrongly");

   a_hf_quiet: assert property (
      !vect_read_fault |=> !hf_req_q)
      else $error("hard fault request without vector fault");

   a_bf_quiet: assert property (
      !bus_fault |=> !bf_req_q)
      else $error("bus fault request without bus fault");

   a_bf_novalid: assert property (
      bus_fault && vect_read_fault && !bf_valid_q |=> !bf_valid_q)
      else $error("vector fault set bus fault valid flag");

   a_bf_hold: assert property (
      !(bus_fault && bus_addr_ok && !vect_read_fault) && !wr_bfa
      |=> bf_addr_q === $past(bf_addr_q))
      else $error("bus fault address changed unprompted");

   a_mm_valid_hold: assert property (
      mm_valid_q && !(wr_fs && pwdata[fac_pkg::FAC_MM_VALID_BIT])
      |=> mm_valid_q)
      else $error("memory fault valid flag lost");

   a_mm_valid_clr: assert property (
      wr_fs && pwdata[fac_pkg::FAC_MM_VALID_BIT]
      && !(mm_fault && mm_addr_ok) |=> !mm_valid_q)
      else $error("memory fault valid flag not cleared");

   a_bf_valid_clr: assert property (
      wr_fs && pwdata[fac_pkg::FAC_BF_VALID_BIT]
      && !(bus_fault && bus_addr_ok && !vect_read_fault) |=> !bf_valid_q)
      else $error("bus fault valid flag not cleared");

   a_mm_no_cap: assert property (
      !mm_valid_q && !(mm_fault && mm_addr_ok) |=> !mm_valid_q)
      else $error("memory fault valid flag set without address");

   a_mm_write: assert property (
      wr_mma && !(mm_fault && mm_addr_ok) |=> mm_addr_q == $past(pwdata))
      else $error("memory fault address write lost");

   a_bf_write: assert property (
      wr_bfa && !(bus_fault && bus_addr_ok && !vect_read_fault)
      |=> bf_addr_q == $past(pwdata))
      else $error("bus fault address write lost");

   a_apb_wait: assert property (
      s_setup |=> pready_q ##1 !pready_q)
      else $error("answer not after one wait state");

   a_mm_read: assert property (
      s_read_ok ##0 reg_sel == fac_pkg::FAC_REG_MM_ADDR
      |=> prdata_q == $past(mm_addr_q))
      else $error("memory fault address read wrongly");

   a_bf_read: assert property (
      s_read_ok ##0 reg_sel == fac_pkg::FAC_REG_BF_ADDR
      |=> prdata_q == $past(bf_addr_q))
      else $error("bus fault address read wrongly");
endmodule : fac_top
`default_nettype wire

// ---- testbench/fac_core_model.sv ----
`default_nettype none
// ********
// Core fault event source
// ********
module fac_core_model (
   input  wire logic        pclk,
   input  wire logic        go,
   input  wire logic [1:0]  kind,
   input  wire logic [31:0] req,
   input  wire logic [31:0] sub,
   output logic             vect_read_fault,
   output logic             mm_fault,
   output logic             bus_fault,
   output logic             addr_ok,
   output logic [31:0]      req_addr,
   output logic [31:0]      sub_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Kind 3 is a memory fault without a usable address
   // Kind 0 is a bus fault on a vector read
   always @(posedge pclk) begin
      vect_read_fault <= go && kind == 2'h0;
      mm_fault <= go && kind[0];
      bus_fault <= go && !kind[0];
      addr_ok <= go && kind != 2'h3;
      req_addr <= go ? req : ~req;
      sub_addr <= go ? sub : ~sub;
   end
endmodule : fac_core_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [2:0]  pprot;
   logic [31:0] pwdata, prdata, req, sub, mm_a, bf_a, rd, ra, sa, r;
   logic [1:0]  kind;
   logic        go, vf, mf, bf, ok, hreq, breq, er, mmv, bfv, vec;
   int          fails, tests_run, seed;
   fac_top fac_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pprot(pprot),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .vect_read_fault(vf), .mm_fault(mf), .mm_addr_ok(ok),
      .mm_req_addr(ra), .mm_sub_addr(sa), .bus_fault(bf), .bus_addr_ok(ok),
      .bus_req_addr(ra), .bus_sub_addr(sa), .hardfault_req(hreq),
      .busfault_req(breq));
   fac_core_model fac_core_model_i (.pclk(pclk), .go(go), .kind(kind),
      .req(req), .sub(sub), .vect_read_fault(vf), .mm_fault(mf),
      .bus_fault(bf), .addr_ok(ok), .req_addr(ra), .sub_addr(sa));
   always #4 pclk = ~pclk;
   // ********
   // Bench tasks
   // ********
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   function automatic logic [31:0] stat_exp(input logic m, input logic b);
      return {16'h0, b, 7'h0, m, 7'h0};
   endfunction : stat_exp
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic pv);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pprot <= {2'b00, pv};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         conclude();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                         input logic pv, input logic ee);
      apb(1'b0, a, 32'h0, pv);
      check(rd, ee ? 32'h0 : e);
      check({31'h0, er}, {31'h0, ee});
   endtask : rd_chk
   task automatic fire(input logic [1:0] k, input logic [31:0] q,
                       input logic [31:0] s);
      go <= 1'b1;
      kind <= k;
      req <= q;
      sub <= s;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      #1;
      check({31'h0, hreq}, {31'h0, k == 2'h0});
      check({31'h0, breq}, {31'h0, k == 2'h2});
      if (k == 2'h0) vec = 1'b1;
      if (k == 2'h1) begin
         mm_a = s;
         mmv = 1'b1;
      end
      if (k == 2'h2) begin
         bf_a = q;
         bfv = 1'b1;
      end
      @(posedge pclk);
   endtask : fire
   // ********
   // Main sequence
   // ********
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, go, mmv, bfv, vec} = 7'h00;
      {paddr, pprot, kind} = 17'h00000;
      {pwdata, req, sub, mm_a, bf_a} = 160'h0;
      fails = 0;
      tests_run = 0;
      seed = 40896;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(fac_pkg::FAC_OFS_FLT_STAT, 32'h0, 1'b1, 1'b0);
      rd_chk(fac_pkg::FAC_OFS_HF_STAT, 32'h0, 1'b1, 1'b0);
      rd_chk(12'hD30, 32'h0, 1'b1, 1'b1);
      rd_chk(fac_pkg::FAC_OFS_MM_ADDR, 32'h0, 1'b0, 1'b1);
      for (int i = 0; i < 24; i++) begin
         r = $random(seed);
         fire(i < 4 ? i[1:0] : r[1:0], $random(seed), $random(seed));
         rd_chk(fac_pkg::FAC_OFS_FLT_STAT, stat_exp(mmv, bfv), 1'b1,
                1'b0);
         rd_chk(fac_pkg::FAC_OFS_HF_STAT, {30'h0, vec, 1'b0}, 1'b1,
                1'b0);
         if (mmv) rd_chk(fac_pkg::FAC_OFS_MM_ADDR, mm_a, 1'b1, 1'b0);
         if (bfv) rd_chk(fac_pkg::FAC_OFS_BF_ADDR, bf_a, 1'b1, 1'b0);
      end
      apb(1'b1, fac_pkg::FAC_OFS_HF_STAT, 32'h0, 1'b1);
      rd_chk(fac_pkg::FAC_OFS_HF_STAT, 32'h2, 1'b1, 1'b0);
      apb(1'b1, fac_pkg::FAC_OFS_HF_STAT, 32'h2, 1'b1);
      rd_chk(fac_pkg::FAC_OFS_HF_STAT, 32'h0, 1'b1, 1'b0);
      apb(1'b1, fac_pkg::FAC_OFS_FLT_STAT, 32'h8080, 1'b1);
      rd_chk(fac_pkg::FAC_OFS_FLT_STAT, 32'h0, 1'b1, 1'b0);
      rd_chk(fac_pkg::FAC_OFS_BF_ADDR, bf_a, 1'b1, 1'b0);
      apb(1'b1, fac_pkg::FAC_OFS_MM_ADDR, 32'hA5A55A5A, 1'b1);
      rd_chk(fac_pkg::FAC_OFS_MM_ADDR, 32'hA5A55A5A, 1'b1, 1'b0);
      apb(1'b1, fac_pkg::FAC_OFS_BF_ADDR, 32'h0F1E2D3C, 1'b1);
      bf_a = 32'h0F1E2D3C;
      rd_chk(fac_pkg::FAC_OFS_BF_ADDR, bf_a, 1'b1, 1'b0);
      apb(1'b1, fac_pkg::FAC_OFS_BF_ADDR, 32'h12345678, 1'b0);
      check({31'h0, er}, 32'h1);
      rd_chk(fac_pkg::FAC_OFS_BF_ADDR, bf_a, 1'b1, 1'b0);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
